// [inc/cdi_pkg.sv]
package cdi_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] CDI_IDX_RATE  = 8'h3f; // Secondary port rate code
  localparam logic [7:0] CDI_IDX_RHI   = 8'h40; // Ratio, upper six bits
  localparam logic [7:0] CDI_IDX_RLO   = 8'h41; // Ratio, lower eight bits
  localparam logic [7:0] CDI_IDX_ICFG  = 8'h42; // Interrupt configuration
  localparam logic [7:0] CDI_IDX_LATCH = 8'h44; // Latched event bits
  localparam logic [7:0] CDI_IDX_LIVE  = 8'h45; // Live event bits

  // Widths and reset values
  localparam int         CDI_REG_W     = 8;     // Register data width
  localparam int         CDI_RATE_W    = 6;     // Rate code width
  localparam int         CDI_RATIO_W   = 14;    // Full ratio width
  localparam int         CDI_RHI_W     = 6;     // Ratio high part width
  localparam int         CDI_RLO_W     = 8;     // Ratio low part width
  localparam int         CDI_RATE_LSB  = 2;     // Rate code position
  localparam logic [7:0] CDI_ICFG_RST  = 8'h00; // Config reset value
  localparam logic [7:0] CDI_STS_RST   = 8'h00; // Status reset value

  // Valid rate codes
  localparam logic [5:0] CDI_RATE_MIN  = 6'h01; // Highest nominal rate
  localparam logic [5:0] CDI_RATE_MAX  = 6'h28; // Lowest nominal rate

  // Configuration field positions
  localparam int CDI_POL_B = 7; // Interrupt polarity
  localparam int CDI_EVT_H = 6; // Event select, upper bit
  localparam int CDI_EVT_L = 5; // Event select, lower bit
  localparam int CDI_PDS_H = 4; // Fault power-down select, upper bit
  localparam int CDI_PDS_L = 3; // Fault power-down select, lower bit
  localparam int CDI_RDB_B = 2; // Latched readback select
  localparam int CDI_RCV_B = 1; // Fault recovery select
  localparam int CDI_CLR_B = 0; // Latch clear policy

  // Interrupt pulse timing
  localparam int CDI_CLK_KHZ   = 125000; // System clock rate
  localparam int CDI_PULSE_MS  = 2;      // Pulse width
  localparam int CDI_PERIOD_MS = 4;      // Repeat period
  localparam int CDI_PULSE_CYC  = CDI_PULSE_MS * CDI_CLK_KHZ;
  localparam int CDI_PERIOD_CYC = CDI_PERIOD_MS * CDI_CLK_KHZ;

  // Interrupt event behaviours
  typedef enum logic [1:0] {
    CDI_EV_LATCHED  = 2'b00,
    CDI_EV_LIVE     = 2'b01,
    CDI_EV_PERIODIC = 2'b10,
    CDI_EV_ONESHOT  = 2'b11
  } cdi_evmode_t;

  // Fault power-down selections
  typedef enum logic [1:0] {
    CDI_PD_NONE     = 2'b00,
    CDI_PD_UNMASKED = 2'b01,
    CDI_PD_ALL      = 2'b10,
    CDI_PD_RSVD     = 2'b11
  } cdi_pdsel_t;

  // Pulse generator states
  typedef enum logic [1:0] {
    CDI_IG_IDLE = 2'b00,
    CDI_IG_ON   = 2'b01,
    CDI_IG_OFF  = 2'b10
  } cdi_igst_t;

endpackage

// [inc/cdi_irq_if.sv]
`timescale 1ns/100ps
// Event summary and settings handed to the interrupt pin generator
interface cdi_irq_if;
  import cdi_pkg::*;
  logic        pol;     // 1 = active high pin
  cdi_evmode_t mode;    // Event behaviour
  logic        pend;    // Unmasked latched event pending
  logic        live;    // Unmasked live event present
  logic        new_evt; // Unmasked event rose this cycle

  modport src (output pol, mode, pend, live, new_evt);
  modport gen (input  pol, mode, pend, live, new_evt);
endinterface

// [core/cdi_irq_gen.sv]
`timescale 1ns/100ps
module cdi_irq_gen
  import cdi_pkg::*;
#(
  parameter int PULSE_CYC  = CDI_PULSE_CYC,  // Pulse width in cycles
  parameter int PERIOD_CYC = CDI_PERIOD_CYC  // Repeat period in cycles
) (
  input  wire logic clk_sys, // System clock
  input  wire logic sys_rst, // Synchronous reset
  cdi_irq_if.gen    ev,      // Event summary
  output logic      irq_o    // Interrupt pin level
);

  localparam int CW = $clog2(PERIOD_CYC + 1); // Counter width
  localparam logic [CW-1:0] ON_END  = CW'(PULSE_CYC - 1);
  localparam logic [CW-1:0] OFF_END = CW'(PERIOD_CYC - PULSE_CYC - 1);

  cdi_igst_t     st_ff;     // Pulse state
  cdi_igst_t     nxt_st;    // Next pulse state
  logic [CW-1:0] cnt_ff;    // Cycles spent in state
  logic [CW-1:0] nxt_cnt;   // Next count
  logic          irq_ff;    // Registered pin
  logic          nxt_irq;   // Next pin
  logic          act;       // Interrupt asserted, before polarity

  // Pulse timing and pin level
  always_comb begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff + CW'(1);
    case (st_ff)
      CDI_IG_IDLE: begin
        nxt_cnt = '0;
        if ((ev.mode == CDI_EV_PERIODIC && ev.pend) ||
            (ev.mode == CDI_EV_ONESHOT && ev.new_evt)) begin // R9
          nxt_st = CDI_IG_ON;
        end
      end
      CDI_IG_ON: begin
        if (cnt_ff == ON_END) begin // R9
          nxt_cnt = '0;
          nxt_st  = (ev.mode == CDI_EV_PERIODIC) ? CDI_IG_OFF : CDI_IG_IDLE;
        end
      end
      CDI_IG_OFF: begin
        // Only the repeating mode rests here; a new period needs a pending event
        if (cnt_ff == OFF_END) begin // R9
          nxt_cnt = '0;
          nxt_st  = ev.pend ? CDI_IG_ON : CDI_IG_IDLE;
        end
      end
      default: begin
        nxt_st  = CDI_IG_IDLE;
        nxt_cnt = '0;
      end
    endcase
    // Level modes never run the pulse timer
    if (ev.mode == CDI_EV_LATCHED || ev.mode == CDI_EV_LIVE) begin
      nxt_st  = CDI_IG_IDLE;
      nxt_cnt = '0;
    end
    case (ev.mode)
      CDI_EV_LATCHED: act = ev.pend; // R9
      CDI_EV_LIVE:    act = ev.live; // R9
      default:        act = (st_ff == CDI_IG_ON);
    endcase
    nxt_irq = ev.pol ? act : ~act; // R8
  end

  // Pin idles high, which is the inactive level after reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_ff  <= CDI_IG_IDLE;
      cnt_ff <= '0;
      irq_ff <= 1'b1;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
      irq_ff <= nxt_irq;
    end
  end

  assign irq_o = irq_ff;

  sequence s_shot_start;
    st_ff == CDI_IG_IDLE && ev.mode == CDI_EV_ONESHOT && ev.new_evt;
  endsequence

  chk_irq_polarity: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ev.mode == CDI_EV_LATCHED |=>
      irq_o == ($past(ev.pol) ? $past(ev.pend) : !$past(ev.pend))) // R8
    else $error("Pin level does not follow polarity");

  chk_shot_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_shot_start |=> st_ff == CDI_IG_ON && cnt_ff == '0
      ##1 (irq_o == ev.pol) || ev.mode != $past(ev.mode)) // R9
    else $error("One-shot pulse did not start");

  chk_pulse_width: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_ff == CDI_IG_ON && cnt_ff == ON_END && ev.mode[1] |=>
      st_ff != CDI_IG_ON) // R9
    else $error("Pulse longer than its width");
endmodule

// [core/cdi_clock_detect_regs.sv]
`timescale 1ns/100ps
// What this block does
// R1 - Secondary rate code in bits 7-2 at 0x3F
// R2 - Codes 1..40 valid, others reserved
// R3 - Reserved status bits read zero
// R4 - Ratio upper six bits at 0x40
// R5 - Ratio lower eight bits at 0x41
// R6 - Status read-only, zero until detection
// R7 - Interrupt configuration read-write at 0x42, reset zero
// R8 - Polarity bit selects low or high pin
// R9 - Four event behaviours incl. 2 ms pulses
// R10 - Clear policy decides clear-on-read of latches
// R11 - Fault power-down select: none, unmasked, all
// R12 - Software joins high and low into 14 bits
module cdi_clock_detect_regs
  import cdi_pkg::*;
#(
  parameter int NUM_EVT    = 8,              // Event inputs, at most 8
  parameter int ADR_W      = 10,             // Byte address width
  parameter int PULSE_CYC  = CDI_PULSE_CYC,  // Interrupt pulse cycles
  parameter int PERIOD_CYC = CDI_PERIOD_CYC  // Interrupt period cycles
) (
  input  wire logic               clk_sys,     // System clock
  input  wire logic               sys_rst,     // Synchronous reset
  input  wire logic               wb_cyc_i,    // Bus cycle
  input  wire logic               wb_stb_i,    // Bus strobe
  input  wire logic               wb_we_i,     // Write enable
  input  wire logic [ADR_W-1:0]   wb_adr_i,    // Byte address
  input  wire logic [3:0]         wb_sel_i,    // Byte selects
  input  wire logic [31:0]        wb_dat_i,    // Write data
  output logic      [31:0]        wb_dat_o,    // Read data
  output logic                    wb_ack_o,    // Acknowledge
  input  wire logic               det_valid_i, // Detection result strobe
  input  wire logic [5:0]         rate_code_i, // Detected rate code
  input  wire logic [13:0]        ratio_i,     // Detected ratio
  input  wire logic [NUM_EVT-1:0] evt_live_i,  // Live event or fault bits
  input  wire logic [NUM_EVT-1:0] evt_mask_i,  // 1 = event masked
  output logic                    irq_o,       // Interrupt pin
  output logic                    chan_pd_o    // Channel and bias power-down
);

  // Register index from a word-aligned byte address
  function automatic logic [7:0] idx_of(input logic [ADR_W-1:0] a);
    idx_of = 8'(a >> 2);
  endfunction

  // Rate code within the documented table
  function automatic logic rate_ok(input logic [5:0] c);
    rate_ok = (c >= CDI_RATE_MIN) && (c <= CDI_RATE_MAX);
  endfunction

  logic [7:0]         idx;        // Decoded index
  logic               req;        // New request this cycle
  logic               go;         // Request completes this edge
  logic               wr_go;      // Write takes effect
  logic               rd_go;      // Read completes
  logic               ack_ff;     // Acknowledge
  logic               nxt_ack;    // Next acknowledge
  logic [31:0]        rdat_ff;    // Read data
  logic [31:0]        nxt_rdat;   // Next read data

  logic [5:0]         rate_ff;    // Secondary port rate code
  logic [5:0]         nxt_rate;   // Next rate code
  logic [13:0]        ratio_ff;   // Frame to clock ratio
  logic [13:0]        nxt_ratio;  // Next ratio
  logic [7:0]         icfg_ff;    // Interrupt configuration
  logic [7:0]         nxt_icfg;   // Next configuration
  logic [NUM_EVT-1:0] latch_ff;   // Latched events
  logic [NUM_EVT-1:0] nxt_latch;  // Next latched events
  logic [NUM_EVT-1:0] live_d_ff;  // Live bits, one cycle late
  logic [NUM_EVT-1:0] rise;       // Live bits that rose
  logic [NUM_EVT-1:0] clr;        // Latch bits cleared by this read
  logic               pd_ff;      // Power-down output
  logic               nxt_pd;     // Next power-down
  logic               flt;        // Fault counted for power-down
  logic [7:0]         latch_rd;   // Latched bits as read back
  cdi_pdsel_t         pdsel;      // Power-down select field

  cdi_irq_if ev ();               // Summary for the pin generator

  assign idx   = idx_of(wb_adr_i);
  assign req   = wb_cyc_i && wb_stb_i && !ack_ff;
  // Writes and read side effects land on the edge the master sees ack
  assign go    = wb_cyc_i && wb_stb_i && ack_ff;
  assign wr_go = go && wb_we_i && wb_sel_i[0];
  assign rd_go = go && !wb_we_i;
  assign rise  = evt_live_i & ~live_d_ff;
  assign pdsel = cdi_pdsel_t'(icfg_ff[CDI_PDS_H:CDI_PDS_L]);

  // Readback view of latches, optionally hiding masked bits
  always_comb begin
    latch_rd = '0;
    latch_rd[NUM_EVT-1:0] = icfg_ff[CDI_RDB_B] ? (latch_ff & ~evt_mask_i)
                                               : latch_ff;
  end

  // Bus answer: one wait state, data registered with ack
  always_comb begin
    nxt_ack  = req;
    nxt_rdat = rdat_ff;
    if (req) begin
      nxt_rdat = '0; // Unmapped indices and reserved bits read zero
      if (!wb_we_i) begin
        case (idx)
          CDI_IDX_RATE: nxt_rdat[7:CDI_RATE_LSB] = rate_ff; // R1 R3
          CDI_IDX_RHI:  nxt_rdat[CDI_RHI_W-1:0] =
                          ratio_ff[CDI_RATIO_W-1:CDI_RLO_W]; // R4 R3
          CDI_IDX_RLO:  nxt_rdat[CDI_RLO_W-1:0] =
                          ratio_ff[CDI_RLO_W-1:0]; // R5
          CDI_IDX_ICFG: nxt_rdat[CDI_REG_W-1:0] = icfg_ff; // R7
          CDI_IDX_LATCH: nxt_rdat[CDI_REG_W-1:0] = latch_rd;
          CDI_IDX_LIVE: nxt_rdat[NUM_EVT-1:0] = evt_live_i;
          default:      nxt_rdat = '0;
        endcase
      end
    end
  end

  // Bus registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_ff  <= 1'b0;
      rdat_ff <= '0;
    end else begin
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  // Status capture, configuration, latches and power-down
  always_comb begin
    nxt_rate  = rate_ff;
    nxt_ratio = ratio_ff;
    nxt_icfg  = icfg_ff;
    // Status moves only with a detection result, never by a bus write
    if (det_valid_i) begin // R6
      // Reserved detector codes are reported as code zero
      nxt_rate  = rate_ok(rate_code_i) ? rate_code_i : 6'h00; // R2
      nxt_ratio = ratio_i; // R4 R5
    end
    if (wr_go && idx == CDI_IDX_ICFG) begin
      nxt_icfg = wb_dat_i[CDI_REG_W-1:0]; // R7
    end
    // Policy 1 clears every bit; policy 0 only those whose live bit is low
    clr = '0;
    if (rd_go && idx == CDI_IDX_LATCH) begin
      clr = icfg_ff[CDI_CLR_B] ? '1 : ~evt_live_i; // R10
    end
    // A rising event in the clearing cycle still latches
    nxt_latch = (latch_ff & ~clr) | rise;
    case (pdsel)
      CDI_PD_UNMASKED: flt = |(evt_live_i & ~evt_mask_i); // R11
      CDI_PD_ALL:      flt = |evt_live_i; // R11
      default:         flt = 1'b0; // R11
    endcase
    // Manual recovery keeps power-down until the latch read after the fault
    if (icfg_ff[CDI_RCV_B]) begin
      nxt_pd = flt || (pd_ff && !(rd_go && idx == CDI_IDX_LATCH));
    end else begin
      nxt_pd = flt;
    end
  end

  // State registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rate_ff   <= CDI_STS_RST[CDI_RATE_W-1:0]; // R6
      ratio_ff  <= '0; // R6
      icfg_ff   <= CDI_ICFG_RST; // R7
      latch_ff  <= '0;
      live_d_ff <= '0;
      pd_ff     <= 1'b0;
    end else begin
      rate_ff   <= nxt_rate;
      ratio_ff  <= nxt_ratio;
      icfg_ff   <= nxt_icfg;
      latch_ff  <= nxt_latch;
      live_d_ff <= evt_live_i;
      pd_ff     <= nxt_pd;
    end
  end

  // Unmasked event summary for the pin generator
  assign ev.pol     = icfg_ff[CDI_POL_B]; // R8
  assign ev.mode    = cdi_evmode_t'(icfg_ff[CDI_EVT_H:CDI_EVT_L]); // R9
  assign ev.pend    = |(latch_ff & ~evt_mask_i);
  assign ev.live    = |(evt_live_i & ~evt_mask_i);
  assign ev.new_evt = |(rise & ~evt_mask_i);

  cdi_irq_gen #(
    .PULSE_CYC  (PULSE_CYC),
    .PERIOD_CYC (PERIOD_CYC)
  ) u_irq (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .ev      (ev),
    .irq_o   (irq_o)
  );

  assign wb_ack_o  = ack_ff;
  assign wb_dat_o  = rdat_ff;
  assign chan_pd_o = pd_ff;

  sequence s_read(logic [7:0] i);
    req && !wb_we_i && idx == i;
  endsequence

  chk_rate_field: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_read(CDI_IDX_RATE) |=> wb_ack_o && wb_dat_o[7:2] == $past(rate_ff)
      && wb_dat_o[1:0] == 2'h0) // R1
    else $error("Rate code read back wrong");

  chk_rate_legal: assert property (@(posedge clk_sys) disable iff (sys_rst)
    det_valid_i && !rate_ok(rate_code_i) |=> rate_ff == 6'h00) // R2
    else $error("Reserved rate code reported");

  chk_high_reserved: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_read(CDI_IDX_RHI) |=> wb_dat_o[31:6] == 26'h0) // R3
    else $error("Reserved ratio bits not zero");

  chk_ratio_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
    det_valid_i ##1 s_read(CDI_IDX_RHI) |=>
      wb_dat_o[5:0] == $past(ratio_i, 2) >> 8) // R4
    else $error("Ratio high part wrong");

  chk_ratio_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
    det_valid_i ##1 s_read(CDI_IDX_RLO) |=>
      wb_dat_o[7:0] == $past(ratio_i[7:0], 2)) // R5
    else $error("Ratio low part wrong");

  chk_status_ro: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !det_valid_i |=> $stable(rate_ff) && $stable(ratio_ff)) // R6
    else $error("Status changed without detection");

  chk_cfg_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_go && idx == CDI_IDX_ICFG ##2 s_read(CDI_IDX_ICFG) |=>
      wb_dat_o[7:0] == $past(wb_dat_i[7:0], 3)) // R7
    else $error("Configuration write lost");

  chk_clear_live: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_go && idx == CDI_IDX_LATCH && !icfg_ff[CDI_CLR_B] |=>
      (latch_ff & $past(evt_live_i)) ==
      (($past(latch_ff) | $past(rise)) & $past(evt_live_i))) // R10
    else $error("Latch cleared while live");

  chk_pd_none: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pdsel == CDI_PD_NONE && !icfg_ff[CDI_RCV_B] |=> !chan_pd_o) // R11
    else $error("Power-down without fault selection");
endmodule

// [testbench/cdi_clock_detect_regs_tb.sv]
`timescale 1ns/100ps
module cdi_clock_detect_regs_tb;
  import cdi_pkg::*;

  // Short pulse timing keeps the run brief
  localparam int          PCYC   = 8;                    // Pulse width
  localparam int          RCYC   = 16;                   // Repeat period
  localparam logic [9:0]  A_RATE = {CDI_IDX_RATE, 2'b00}; // Rate code
  localparam logic [9:0]  A_RHI  = {CDI_IDX_RHI, 2'b00};  // Ratio high
  localparam logic [9:0]  A_RLO  = {CDI_IDX_RLO, 2'b00};  // Ratio low
  localparam logic [9:0]  A_ICFG = {CDI_IDX_ICFG, 2'b00}; // Config
  localparam logic [9:0]  A_LTCH = {CDI_IDX_LATCH, 2'b00}; // Latches

  logic        clk_sys   = 1'b0;   // System clock
  logic        sys_rst   = 1'b1;   // Synchronous reset
  logic        wb_cyc    = 1'b0;   // Bus cycle
  logic        wb_stb    = 1'b0;   // Bus strobe
  logic        wb_we     = 1'b0;   // Write enable
  logic [9:0]  wb_adr    = '0;     // Byte address
  logic [3:0]  wb_sel    = 4'h0;   // Byte selects
  logic [31:0] wb_dat_wr = '0;     // Write data
  logic [31:0] wb_dat_o;           // Read data
  logic        wb_ack_o;           // Acknowledge
  logic        det_valid = 1'b0;   // Detection strobe
  logic [5:0]  rate_code = '0;     // Detected code
  logic [13:0] ratio     = '0;     // Detected ratio
  logic [7:0]  evt_live  = '0;     // Live events
  logic [7:0]  evt_mask  = '0;     // Event masks
  logic        irq_o;              // Interrupt pin
  logic        chan_pd_o;          // Power-down
  logic [31:0] exp_q[$];           // Expected read data, oldest first
  logic [31:0] exp_v;              // Note taken off the queue
  int          err_total = 0;      // Mismatches
  int          checks    = 0;      // Comparisons

  always #4 clk_sys = ~clk_sys;

  cdi_clock_detect_regs #(.PULSE_CYC(PCYC), .PERIOD_CYC(RCYC)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_wr), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .det_valid_i(det_valid), .rate_code_i(rate_code),
    .ratio_i(ratio), .evt_live_i(evt_live), .evt_mask_i(evt_mask),
    .irq_o(irq_o), .chan_pd_o(chan_pd_o));

  // Verdict and end of run, reached from the sequence and the watchdog
  task automatic test_done();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp_v(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_b(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic cmp_n(input string nm, input int e, input int g);
    checks++;
    if (g != e) begin
      err_total++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // Read data is judged where the ack is sampled, not by the driver
  always @(posedge clk_sys) begin
    if (wb_ack_o === 1'b1 && wb_we === 1'b0) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("CHECK FAILED read without note expected none seen %h",
                 wb_dat_o);
      end else begin
        exp_v = exp_q.pop_front();
        cmp_v("read data", exp_v, wb_dat_o);
      end
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One classic cycle; entered just after a rising edge
  task automatic wb_xfer(input logic we, input logic [9:0] adr,
                         input logic [3:0] sel, input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc    <= 1'b1;
    wb_stb    <= 1'b1;
    wb_we     <= we;
    wb_adr    <= adr;
    wb_sel    <= sel;
    wb_dat_wr <= {24'h000000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("CHECK FAILED bus ack expected 1 seen none");
      test_done();
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [9:0] adr, input logic [7:0] d);
    wb_xfer(1'b1, adr, 4'hf, d);
  endtask

  task automatic rd(input logic [9:0] adr, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    wb_xfer(1'b0, adr, 4'hf, 8'h00);
  endtask

  // Counts active pin cycles over a window
  task automatic count_on(input int win, input logic act, output int c);
    c = 0;
    repeat (win) begin
      @(posedge clk_sys);
      #1;
      if (irq_o === act) c++;
    end
  endtask

  task automatic pin_irq(input int n, input logic e);
    cyc(n);
    #1 cmp_b("irq_o", e, irq_o);
  endtask

  // Watchdog against any hang
  initial begin
    cyc(50000);
    err_total++;
    $display("CHECK FAILED run length expected end seen timeout");
    test_done();
  end

  initial begin
    logic [7:0]  r;
    logic [5:0]  codes[6];
    logic [13:0] rt;
    int          c;
    void'($urandom(32'hcc1d705c));
    cyc(6);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    // Reset values and access kinds
    rd(A_RATE, 8'h00);
    rd(A_RHI, 8'h00);
    rd(A_RLO, 8'h00);
    rd(A_ICFG, 8'h00);
    r = 8'($urandom());
    wb_xfer(1'b1, A_ICFG, 4'h1, r);
    rd(A_ICFG, r);
    wb_xfer(1'b1, A_ICFG, 4'he, ~r);
    rd(A_ICFG, r);
    wr(A_RATE, 8'hff);
    wr(A_RLO, 8'hff);
    rd(A_RATE, 8'h00);
    rd(A_RLO, 8'h00);
    rd(10'h3fc, 8'h00);
    wr(A_ICFG, 8'h00);
    // Detection results, boundary and reserved codes included
    codes = '{6'd0, 6'd1, 6'd40, 6'd41, 6'd63, 6'(1 + $urandom_range(39))};
    foreach (codes[i]) begin
      rt = 14'($urandom());
      r = (codes[i] >= CDI_RATE_MIN && codes[i] <= CDI_RATE_MAX) ?
          {codes[i], 2'b00} : 8'h00;
      det_valid <= 1'b1;
      rate_code <= codes[i];
      ratio     <= rt;
      @(posedge clk_sys);
      det_valid <= 1'b0;
      // Rotate the first read so each kind follows a detection directly
      for (int k = 0; k < 3; k++) begin
        case ((i + k) % 3)
          0:       rd(A_RATE, r);
          1:       rd(A_RHI, {2'b00, rt[13:8]});
          default: rd(A_RLO, rt[7:0]);
        endcase
      end
    end
    // Latched mode, active low
    pin_irq(1, 1'b1);
    evt_live[0] <= 1'b1;
    pin_irq(2, 1'b0);
    evt_live[0] <= 1'b0;
    pin_irq(3, 1'b0);
    rd(A_LTCH, 8'h01);
    pin_irq(2, 1'b1);
    // Clear policy with the live bit still high
    evt_live[0] <= 1'b1;
    cyc(3);
    rd(A_LTCH, 8'h01);
    rd(A_LTCH, 8'h01);
    wr(A_ICFG, 8'h01);
    rd(A_LTCH, 8'h01);
    rd(A_LTCH, 8'h00);
    evt_live[0] <= 1'b0;
    // Active high pin, then live mode
    wr(A_ICFG, 8'h80);
    pin_irq(2, 1'b0);
    wr(A_ICFG, 8'ha0);
    evt_live[3] <= 1'b1;
    pin_irq(2, 1'b1);
    evt_live[3] <= 1'b0;
    pin_irq(2, 1'b0);
    // Periodic pulses while bit 3 stays latched
    wr(A_ICFG, 8'hc0);
    cyc(20);
    count_on(2 * RCYC, 1'b1, c);
    cmp_n("periodic on cycles", 2 * PCYC, c);
    rd(A_LTCH, 8'h08);
    // Let the running period finish so the next event finds the timer idle
    cyc(RCYC);
    // One pulse per event
    wr(A_ICFG, 8'he0);
    evt_live[4] <= 1'b1;
    count_on(5 * PCYC, 1'b1, c);
    cmp_n("one-shot on cycles", PCYC, c);
    evt_live[4] <= 1'b0;
    wr(A_ICFG, 8'h80);
    rd(A_LTCH, 8'h10);
    // Masked event: no pin, readback per select
    evt_mask[5] <= 1'b1;
    evt_live[5] <= 1'b1;
    pin_irq(3, 1'b0);
    rd(A_LTCH, 8'h20);
    wr(A_ICFG, 8'h84);
    rd(A_LTCH, 8'h00);
    // Fault power-down selections with a masked fault present
    wr(A_ICFG, 8'h08);
    cyc(2);
    #1 cmp_b("chan_pd_o", 1'b0, chan_pd_o);
    wr(A_ICFG, 8'h18);
    cyc(2);
    #1 cmp_b("chan_pd_o", 1'b0, chan_pd_o);
    wr(A_ICFG, 8'h00);
    cyc(2);
    #1 cmp_b("chan_pd_o", 1'b0, chan_pd_o);
    wr(A_ICFG, 8'h10);
    cyc(2);
    #1 cmp_b("chan_pd_o", 1'b1, chan_pd_o);
    wr(A_ICFG, 8'h08);
    evt_mask[5] <= 1'b0;
    cyc(2);
    #1 cmp_b("chan_pd_o", 1'b1, chan_pd_o);
    // Manual recovery holds power-down until a latch read
    wr(A_ICFG, 8'h0a);
    evt_live[5] <= 1'b0;
    cyc(3);
    #1 cmp_b("chan_pd_o", 1'b1, chan_pd_o);
    rd(A_LTCH, 8'h20);
    cyc(2);
    #1 cmp_b("chan_pd_o", 1'b0, chan_pd_o);
    cyc(2);
    cmp_n("notes left", 0, exp_q.size());
    test_done();
  end
endmodule
